// File: dv/dlrc_core_monitor.sv
/* Port checker for the update-control block.
   Assumes it is bound to dlrc_core and that select only changes under reset. */
`default_nettype none
module dlrc_core_monitor (
    input wire logic                 clock,
    input wire logic                 rst,
    input wire logic                 ce,
    input wire logic                 sync_n,
    input wire logic                 load_strobe_n,
    input wire logic                 clear_n,
    input wire logic                 clear_level_select,
    input wire dlrc_pkg::dlrc_code_t dac_a,
    input wire dlrc_pkg::dlrc_code_t dac_b,
    input wire dlrc_pkg::dlrc_mask_t mask,
    input wire logic                 por_busy
);
    timeunit 1ns;
    timeprecision 1ps;
    import dlrc_pkg::*;
    dlrc_code_t clr_code;
    logic [7:0] por_cnt_reg;
    assign clr_code = clear_level_select ? 10'h200 : 10'h000;
    always_ff @(posedge clock or posedge rst) begin
        if (rst)
            por_cnt_reg <= 8'h00;
        else if (por_busy && ce)
            por_cnt_reg <= por_cnt_reg + 8'h01;
    end
    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);
    // ==========================================================
    // assertions
    // ==========================================================
    chk_mask_reset: assert property ($fell(rst) |-> mask == 4'h0 && por_busy)
        else $error("mask not clear after reset");
    chk_por_length: assert property ($fell(por_busy) |-> por_cnt_reg >= 8'h27
        && por_cnt_reg <= 8'h29) else $error("power-on window length wrong");
    chk_por_codes: assert property (por_busy |-> dac_a == dac_b
        && (dac_a == 10'h000 || dac_a == 10'h200)) else $error("output moved in power-on");
    chk_por_end: assert property ($fell(por_busy) |-> dac_a == clr_code
        && dac_b == clr_code) else $error("power-up code wrong");
    chk_clear_code: assert property ((!clear_n && !por_busy) [*8] |-> dac_a == clr_code
        && dac_b == clr_code) else $error("outputs not held at clear code");
    chk_mask_change: assert property ($changed(mask) |-> sync_n && $past(sync_n, 3))
        else $error("mask changed outside frame end");
    chk_frame_quiet: assert property (!sync_n && !$past(sync_n, 8) && load_strobe_n
        && $past(load_strobe_n, 8) && clear_n && $past(clear_n, 8) && !por_busy
        |-> $stable(dac_a) && $stable(dac_b)) else $error("output moved inside frame");
    chk_mask_a_block: assert property ($fell(load_strobe_n) && mask[0] && sync_n
        && clear_n && !por_busy |=> $stable(dac_a) [*8]) else $error("masked A updated");
    chk_mask_b_block: assert property ($fell(load_strobe_n) && mask[3] && sync_n
        && clear_n && !por_busy |=> $stable(dac_b) [*8]) else $error("masked B updated");
    cover property ($fell(load_strobe_n) && mask == 4'h0 && !por_busy);
    cover property ($fell(por_busy) && clear_level_select);
    cover property ((!clear_n && !por_busy) [*8]);
endmodule // dlrc_core_monitor
bind dlrc_core dlrc_core_monitor mon_u (.clock(clock), .rst(rst), .ce(ce), .sync_n(sync_n),
    .load_strobe_n(load_strobe_n), .clear_n(clear_n),
    .clear_level_select(clear_level_select), .dac_a(dac_a), .dac_b(dac_b),
    .mask(mask), .por_busy(por_busy));
`default_nettype wire

// File: dv/dlrc_core_test.sv
/* Self-checking bench for the update-control block: table of frames, then
   clear pin, short frame and power-on cases. Assumes the host model and checker. */
`default_nettype none
module dlrc_core_test;
    timeunit 1ns;
    timeprecision 1ps;
    import dlrc_pkg::*;
    typedef struct packed {
        dlrc_frame_t frame;
        logic        sl;
        logic        pl;
        dlrc_code_t  ea;
        dlrc_code_t  eb;
        dlrc_mask_t  em;
    } dlrc_row_t;
    logic       clock = 1'b0;
    logic       rst = 1'b1;
    logic       ce = 1'b1;
    logic       load_strobe_n = 1'b1;
    logic       clear_n = 1'b1;
    logic       clear_level_select = 1'b0;
    logic       sync_n, sclk, sdin, por_busy;
    dlrc_code_t dac_a, dac_b;
    dlrc_mask_t mask;
    int         num_errors = 0;
    int         compares = 0;
    int         cycles = 0;
    // strobe low before frame (sl), strobe pulse after it (pl)
    dlrc_row_t rows [15] = '{
        '{24'h115540, 1'b0, 1'b0, 10'h000, 10'h000, 4'h0},
        '{24'h18AA80, 1'b0, 1'b1, 10'h155, 10'h2AA, 4'h0},
        '{24'h113C00, 1'b1, 1'b0, 10'h0F0, 10'h2AA, 4'h0},
        '{24'h184440, 1'b0, 1'b0, 10'h0F0, 10'h2AA, 4'h0},
        '{24'h280000, 1'b0, 1'b0, 10'h0F0, 10'h111, 4'h0},
        '{24'h31FFC0, 1'b0, 1'b0, 10'h3FF, 10'h111, 4'h0},
        '{24'h500009, 1'b0, 1'b0, 10'h3FF, 10'h111, 4'h9},
        '{24'h110040, 1'b0, 1'b1, 10'h3FF, 10'h111, 4'h9},
        '{24'h110080, 1'b1, 1'b0, 10'h002, 10'h111, 4'h9},
        '{24'h500008, 1'b0, 1'b0, 10'h002, 10'h111, 4'h8},
        '{24'h18CCC0, 1'b0, 1'b0, 10'h002, 10'h111, 4'h8},
        '{24'h112A80, 1'b0, 1'b1, 10'h0AA, 10'h111, 4'h8},
        '{24'h500001, 1'b0, 1'b0, 10'h0AA, 10'h111, 4'h1},
        '{24'h110040, 1'b0, 1'b1, 10'h0AA, 10'h333, 4'h1},
        '{24'h600000, 1'b0, 1'b0, 10'h000, 10'h000, 4'h0}};

    dlrc_core dut_u (.clock(clock), .rst(rst), .ce(ce), .sync_n(sync_n), .sclk(sclk),
        .sdin(sdin), .load_strobe_n(load_strobe_n), .clear_n(clear_n),
        .clear_level_select(clear_level_select), .dac_a(dac_a), .dac_b(dac_b),
        .mask(mask), .por_busy(por_busy));
    dlrc_host_model host_u (.clock(clock), .sync_n(sync_n), .sclk(sclk), .sdin(sdin));

    always #12.5 clock = ~clock;
    // ==========================================================
    // helpers
    // ==========================================================
    task automatic close_out;
        if (num_errors == 0 && compares > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    always @(posedge clock) begin
        cycles++;
        if (cycles == 20000) begin
            num_errors++;
            close_out();
        end
    end
    task automatic check_code(input dlrc_code_t got, input dlrc_code_t exp);
        compares++;
        if (got !== exp) begin
            num_errors++;
            $display("BAD %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic check_mask(input dlrc_mask_t got, input dlrc_mask_t exp);
        compares++;
        if (got !== exp) begin
            num_errors++;
            $display("BAD %0t got %h exp %h", $time, got, exp);
        end
    endtask
    // low time long enough for the pin synchroniser to see the fall
    task automatic strobe_pulse;
        @(posedge clock);
        load_strobe_n <= 1'b0;
        repeat (10) @(posedge clock);
        load_strobe_n <= 1'b1;
        repeat (12) @(posedge clock);
    endtask
    task automatic wait_por;
        for (int k = 0; k < 100 && por_busy !== 1'b0; k++) @(posedge clock);
        repeat (2) @(posedge clock);
    endtask
    // ==========================================================
    // main sequence
    // ==========================================================
    initial begin
        repeat (5) @(posedge clock);
        rst <= 1'b0;
        wait_por();
        foreach (rows[k]) begin
            if (rows[k].sl) begin
                @(posedge clock);
                load_strobe_n <= 1'b0;
                repeat (12) @(posedge clock);
            end
            host_u.send(rows[k].frame, 24);
            load_strobe_n <= 1'b1;
            if (rows[k].pl)
                strobe_pulse();
            check_code(dac_a, rows[k].ea);
            check_code(dac_b, rows[k].eb);
            check_mask(mask, rows[k].em);
        end
        host_u.send(24'h3148C0, 24);
        check_code(dac_a, 10'h123);
        clear_n <= 1'b0;
        repeat (20) @(posedge clock);
        check_code(dac_a, 10'h000);
        host_u.send(24'h383FC0, 24);
        check_code(dac_b, 10'h000);
        clear_n <= 1'b1;
        repeat (20) @(posedge clock);
        check_code(dac_a, 10'h000);
        host_u.send(24'h31FFC0, 23);
        check_code(dac_a, 10'h000);
        // second reset with midscale select, pin activity inside power-on window
        rst <= 1'b1;
        clear_level_select <= 1'b1;
        repeat (5) @(posedge clock);
        rst <= 1'b0;
        repeat (5) @(posedge clock);
        load_strobe_n <= 1'b0;
        clear_n <= 1'b0;
        repeat (8) @(posedge clock);
        load_strobe_n <= 1'b1;
        clear_n <= 1'b1;
        wait_por();
        check_code(dac_a, 10'h200);
        check_mask(mask, 4'h0);
        host_u.send(24'h111400, 24);
        check_code(dac_a, 10'h200);
        // with the enable low the whole pulse goes unseen
        ce <= 1'b0;
        strobe_pulse();
        ce <= 1'b1;
        check_code(dac_a, 10'h200);
        host_u.send(24'h210000, 24);
        check_code(dac_a, 10'h050);
        // strobe fall reaching the core in the same cycle as a frame end
        host_u.send(24'h182A80, 24);
        fork
            host_u.send(24'h11FFC0, 24);
            begin
                repeat (197) @(posedge clock);
                load_strobe_n <= 1'b0;
            end
        join
        load_strobe_n <= 1'b1;
        check_code(dac_a, 10'h3FF);
        check_code(dac_b, 10'h0AA);
        host_u.send(24'h600000, 24);
        check_code(dac_a, 10'h200);
        check_code(dac_b, 10'h200);
        close_out();
    end
endmodule // dlrc_core_test
`default_nettype wire

// File: dv/dlrc_host_model.sv
/* Host side model: drives frame select, serial clock and data as a bus master.
   Assumes the core clock is free running; pins change only after its rising edge. */
`default_nettype none
module dlrc_host_model (
    input  wire logic clock,
    output var  logic sync_n,
    output var  logic sclk,
    output var  logic sdin
);
    timeunit 1ns;
    timeprecision 1ps;
    import dlrc_pkg::*;
    initial begin
        sync_n = 1'b1;
        sclk = 1'b1;
        sdin = 1'b0;
    end
    // ==========================================================
    // frame sender
    // ==========================================================
    // sclk stands high between frames; a short frame is sent with n below 24
    task automatic send(input dlrc_frame_t f, input int n);
        @(posedge clock);
        sync_n <= 1'b0;
        sdin <= f[23];
        for (int i = 1; i <= n; i++) begin
            repeat (4) @(posedge clock);
            sclk <= 1'b0;
            repeat (4) @(posedge clock);
            sclk <= 1'b1;
            // after the last bit the line is driven to the inverse of that bit
            sdin <= (i < n) ? f[23 - i] : ~f[24 - n];
        end
        repeat (4) @(posedge clock);
        sync_n <= 1'b1;
        repeat (24) @(posedge clock);
    endtask
endmodule // dlrc_host_model
`default_nettype wire

// File: hdl/dlrc_core.sv
/*
 * Update control for a two-channel converter: serial command frames, input and
 * DAC registers per channel, load strobe with mask, hardware and soft clear.
 * Assumes all pins arrive asynchronously to the 40 MHz core clock and that the
 * host drives sync_n, sclk, sdin, load_strobe_n and clear_n as an SPI master.
 */
`default_nettype none
`include "dlrc_regs.svh"

module dlrc_core (
    input  wire logic              clock,
    input  wire logic              rst,
    input  wire logic              ce,
    input  wire logic              sync_n,
    input  wire logic              sclk,
    input  wire logic              sdin,
    input  wire logic              load_strobe_n,
    input  wire logic              clear_n,
    input  wire logic              clear_level_select,
    output var  dlrc_pkg::dlrc_code_t dac_a,
    output var  dlrc_pkg::dlrc_code_t dac_b,
    output var  dlrc_pkg::dlrc_mask_t mask,
    output var  logic              por_busy
);
    import dlrc_pkg::*;

    // ============================================================
    // pin synchronisers
    // ============================================================
    logic sync_n_s;
    logic sclk_s;
    logic sdin_s;
    logic load_strobe_n_s;
    logic clear_s;
    logic sel_s;

    dlrc_sync u_sync_cs (
        .clock       (clock),
        .rst         (rst),
        .ce          (ce),
        .reset_value (1'b1),
        .pin         (sync_n),
        .level       (sync_n_s)
    );
    dlrc_sync u_sync_ck (
        .clock       (clock),
        .rst         (rst),
        .ce          (ce),
        .reset_value (1'b1),
        .pin         (sclk),
        .level       (sclk_s)
    );
    dlrc_sync u_sync_di (
        .clock       (clock),
        .rst         (rst),
        .ce          (ce),
        .reset_value (1'b1),
        .pin         (sdin),
        .level       (sdin_s)
    );
    dlrc_sync u_sync_ld (
        .clock       (clock),
        .rst         (rst),
        .ce          (ce),
        .reset_value (1'b1),
        .pin         (load_strobe_n),
        .level       (load_strobe_n_s)
    );
    dlrc_sync u_sync_cl (
        .clock       (clock),
        .rst         (rst),
        .ce          (ce),
        .reset_value (1'b1),
        .pin         (clear_n),
        .level       (clear_s)
    );
    // the strap is a pin too: latching it raw could catch a half-settled level
    dlrc_sync u_sync_rs (
        .clock       (clock),
        .rst         (rst),
        .ce          (ce),
        .reset_value (1'b1),
        .pin         (clear_level_select),
        .level       (sel_s)
    );

    // ============================================================
    // edge detection on qualified levels
    // ============================================================
    logic sync_prev_reg;
    logic sclk_prev_reg;
    logic load_strobe_n_prev_reg;

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            sync_prev_reg <= 1'b1;
            sclk_prev_reg <= 1'b1;
            load_strobe_n_prev_reg <= 1'b1;
        end else if (ce) begin
            sync_prev_reg <= sync_n_s;
            sclk_prev_reg <= sclk_s;
            load_strobe_n_prev_reg <= load_strobe_n_s;
        end
    end

    logic sclk_fall;
    logic sync_rise;
    logic sync_fall;
    logic load_strobe_n_fall;
    // data is presented by the host on the rising edge, so it is taken on the falling edge
    assign sclk_fall = sclk_prev_reg & ~sclk_s;
    assign sync_rise = ~sync_prev_reg & sync_n_s;
    assign sync_fall = sync_prev_reg & ~sync_n_s;
    assign load_strobe_n_fall = load_strobe_n_prev_reg & ~load_strobe_n_s;

    // ============================================================
    // power-on reset window
    // ============================================================
    logic [15:0] por_cnt_reg;
    logic        clr_sel_reg;

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            por_cnt_reg <= 16'h0000;
            por_busy    <= 1'b1;
        end else if (ce) begin
            if (por_busy) begin
                if (por_cnt_reg == 16'(`DLRC_POR_CYCLES - 1)) begin
                    por_busy <= 1'b0;
                end
                por_cnt_reg <= por_cnt_reg + 16'h0001;
            end
        end
    end

    // select pin is a strap: caught while the power-on window runs
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            clr_sel_reg <= 1'b0;
        end else if (ce) begin
            // the synchroniser starts at one, so wait until it shows the pin
            if (por_busy && (por_cnt_reg >= 16'(`DLRC_SYNC_SETTLE))) begin
                clr_sel_reg <= sel_s;
            end
        end
    end

    // ============================================================
    // frame receiver
    // ============================================================
    dlrc_state_t state_reg;
    logic [23:0] shift_reg;
    logic [4:0]  bit_cnt_reg;
    logic        frame_valid;

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            state_reg   <= DLRC_ST_IDLE;
            shift_reg   <= 24'h000000;
            bit_cnt_reg <= 5'h00;
        end else if (ce) begin
            case (state_reg)
                DLRC_ST_IDLE: begin
                    if (sync_fall) begin
                        state_reg   <= DLRC_ST_SHIFT;
                        bit_cnt_reg <= 5'h00;
                    end
                end
                DLRC_ST_SHIFT: begin
                    if (sync_rise) begin
                        state_reg <= DLRC_ST_IDLE;
                    end else if (sclk_fall) begin
                        shift_reg <= {shift_reg[22:0], sdin_s};
                        if (bit_cnt_reg != 5'(`DLRC_FRAME_BITS)) begin
                            bit_cnt_reg <= bit_cnt_reg + 5'h01;
                        end
                    end
                end
                DLRC_ST_DONE: begin
                    state_reg <= DLRC_ST_IDLE;
                end
                default: begin
                    state_reg <= DLRC_ST_IDLE;
                end
            endcase
        end
    end

    // short frames are dropped; a full 24 bits is needed to act
    assign frame_valid = (state_reg == DLRC_ST_SHIFT) && sync_rise
                       && (bit_cnt_reg == 5'(`DLRC_FRAME_BITS));

    dlrc_cmd_t  cmd;
    logic [3:0] addr;
    dlrc_code_t data;
    assign cmd  = shift_reg[`DLRC_CMD_MSB:`DLRC_CMD_LSB];
    assign addr = shift_reg[`DLRC_ADDR_MSB:`DLRC_ADDR_LSB];
    assign data = shift_reg[`DLRC_DATA_MSB:`DLRC_DATA_LSB];

    // ============================================================
    // command and strobe decode
    // ============================================================
    function automatic logic is_cmd(input logic v, input dlrc_cmd_t c, input dlrc_cmd_t k);
        is_cmd = v && (c == k);
    endfunction

    logic cmd_wr_in;
    logic cmd_upd;
    logic cmd_wr_upd;
    logic cmd_mask;
    logic cmd_soft;
    assign cmd_wr_in  = is_cmd(frame_valid, cmd, `DLRC_CMD_WRITE_INPUT);
    assign cmd_upd    = is_cmd(frame_valid, cmd, `DLRC_CMD_UPDATE_DAC);
    assign cmd_wr_upd = is_cmd(frame_valid, cmd, `DLRC_CMD_WRITE_UPD);
    assign cmd_mask   = is_cmd(frame_valid, cmd, `DLRC_CMD_LOAD_MASK);
    assign cmd_soft   = is_cmd(frame_valid, cmd, `DLRC_CMD_SOFT_RESET);

    logic [1:0] sel;
    logic [1:0] unmasked;
    logic [1:0] strobe_low;
    assign sel = {addr[`DLRC_ADDR_CH_B], addr[`DLRC_ADDR_CH_A]};
    // a level held low means mask bits are ignored; a pulse respects them
    assign unmasked   = ~{mask[`DLRC_MASK_BIT_B], mask[`DLRC_MASK_BIT_A]};
    assign strobe_low = {2{~load_strobe_n_s}};

    // ============================================================
    // register banks
    // ============================================================
    dlrc_code_t in_a_reg;
    dlrc_code_t in_b_reg;
    logic       hold_clear;
    logic       por_code_sel;
    dlrc_code_t clear_code;
    assign hold_clear   = ~clear_s & ~por_busy;
    assign por_code_sel = clr_sel_reg;
    assign clear_code   = por_code_sel ? `DLRC_CODE_MID : `DLRC_CODE_ZERO;

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            mask <= `DLRC_MASK_RESET;
        end else if (ce) begin
            if (cmd_soft) begin
                mask <= `DLRC_MASK_RESET;
            end else if (cmd_mask) begin
                mask <= shift_reg[3:0];
            end
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            in_a_reg <= `DLRC_CODE_ZERO;
            in_b_reg <= `DLRC_CODE_ZERO;
        end else if (ce) begin
            if (por_busy || cmd_soft || hold_clear) begin
                in_a_reg <= clear_code;
                in_b_reg <= clear_code;
            end else if (cmd_wr_in || cmd_wr_upd) begin
                if (sel[0]) begin
                    in_a_reg <= data;
                end
                if (sel[1]) begin
                    in_b_reg <= data;
                end
            end
        end
    end

    logic [1:0] load_dac;
    dlrc_code_t src_a;
    dlrc_code_t src_b;
    logic       load_strobe_n_pend_reg;

    // a strobe fall that meets a frame write is kept one cycle, so the copy
    // then takes the freshly written input value instead of being lost
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            load_strobe_n_pend_reg <= 1'b0;
        end else if (ce) begin
            if (por_busy || cmd_soft || hold_clear) begin
                load_strobe_n_pend_reg <= 1'b0;
            end else begin
                load_strobe_n_pend_reg <= (load_strobe_n_fall | load_strobe_n_pend_reg) & (cmd_wr_in | cmd_wr_upd);
            end
        end
    end

    always_comb begin
        load_dac = 2'b00;
        src_a    = in_a_reg;
        src_b    = in_b_reg;
        if (cmd_wr_upd) begin
            load_dac = sel;
            src_a    = data;
            src_b    = data;
        end else if (cmd_wr_in) begin
            load_dac = sel & strobe_low;
            src_a    = data;
            src_b    = data;
        end else if (cmd_upd) begin
            load_dac = sel;
        end
        // strobe fall outside a frame write copies held input values
        if ((load_strobe_n_fall || load_strobe_n_pend_reg) && !cmd_wr_in && !cmd_wr_upd) begin
            load_dac = load_dac | unmasked;
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            dac_a <= `DLRC_CODE_ZERO;
            dac_b <= `DLRC_CODE_ZERO;
        end else if (ce) begin
            if (por_busy || cmd_soft || hold_clear) begin
                dac_a <= clear_code;
                dac_b <= clear_code;
            end else begin
                // no load means the cleared or power-up code simply stays
                if (load_dac[0]) begin
                    dac_a <= src_a;
                end
                if (load_dac[1]) begin
                    dac_b <= src_b;
                end
            end
        end
    end
endmodule // dlrc_core

`default_nettype wire

// File: hdl/dlrc_pkg.sv
/*
 * Types shared by the update-control block.
 * Assumes dlrc_regs.svh is on the include path.
 */
`default_nettype none
`include "dlrc_regs.svh"

package dlrc_pkg;
    typedef logic [9:0]  dlrc_code_t;
    typedef logic [3:0]  dlrc_cmd_t;
    typedef logic [3:0]  dlrc_mask_t;
    typedef logic [23:0] dlrc_frame_t;
    typedef enum logic [2:0] {
        DLRC_ST_IDLE  = 3'b001,
        DLRC_ST_SHIFT = 3'b010,
        DLRC_ST_DONE  = 3'b100
    } dlrc_state_t;
endpackage : dlrc_pkg

`default_nettype wire

// File: hdl/dlrc_regs.svh
/*
 * Constants for the converter update-control block: command codes, frame layout,
 * data widths, clear codes, power-on hold and synchroniser settle time.
 * Assumes inclusion by bare name from the package and design modules.
 */
`ifndef DLRC_REGS_SVH
`define DLRC_REGS_SVH

// ============================================================
// frame layout
// ============================================================
`define DLRC_FRAME_BITS      24
`define DLRC_CMD_MSB         23
`define DLRC_CMD_LSB         20
`define DLRC_ADDR_MSB        19
`define DLRC_ADDR_LSB        16
`define DLRC_DATA_MSB        15
`define DLRC_DATA_LSB        6
`define DLRC_ADDR_CH_A       0
`define DLRC_ADDR_CH_B       3

// ============================================================
// command codes
// ============================================================
`define DLRC_CMD_WRITE_INPUT 4'h1
`define DLRC_CMD_UPDATE_DAC  4'h2
`define DLRC_CMD_WRITE_UPD   4'h3
`define DLRC_CMD_LOAD_MASK   4'h5
`define DLRC_CMD_SOFT_RESET  4'h6

// ============================================================
// mask register and codes
// ============================================================
`define DLRC_MASK_RESET      4'h0
`define DLRC_MASK_BIT_A      0
`define DLRC_MASK_BIT_B      3
`define DLRC_CODE_ZERO       10'h000
`define DLRC_CODE_MID        10'h200

// ============================================================
// power-on reset hold in clocks of the 40 MHz core clock
// ============================================================
`define DLRC_POR_TIME_NS     1000
`define DLRC_CLK_PERIOD_NS   25
`define DLRC_POR_CYCLES      ((`DLRC_POR_TIME_NS + `DLRC_CLK_PERIOD_NS - 1) / `DLRC_CLK_PERIOD_NS)
// clocks after reset before a pin synchroniser shows the real pin level
`define DLRC_SYNC_SETTLE     5

`endif

// File: hdl/dlrc_sync.sv
/*
 * Three-stage synchroniser with change qualification: the output moves only
 * when stages two and three agree.
 * Assumes a free-running core clock and an asynchronous pin input.
 */
`default_nettype none

module dlrc_sync (
    input  wire logic clock,
    input  wire logic rst,
    input  wire logic ce,
    input  wire logic reset_value,
    input  wire logic pin,
    output var  logic level
);
    logic s1_reg;
    logic s2_reg;
    logic s3_reg;

    // ============================================================
    // stages
    // ============================================================
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            s1_reg <= 1'b1;
            s2_reg <= 1'b1;
            s3_reg <= 1'b1;
            level  <= 1'b1;
        end else if (ce) begin
            s1_reg <= pin;
            s2_reg <= s1_reg;
            s3_reg <= s2_reg;
            if (s2_reg == s3_reg) begin
                level <= s3_reg;
            end
        end
    end

    // reset_value is not used; every stage and the output reset to one for all pins
    logic unused_rv;
    assign unused_rv = reset_value;
endmodule // dlrc_sync

`default_nettype wire
